// *** core/lacc_regs.vh ***
// Constants for the load-adaptive current control block: APB offsets,
// configuration word field positions, reset values and threshold, filter and scale constants.
// Assumes inclusion by bare name from the design files of this block.
`ifndef LACC_REGS_VH
`define LACC_REGS_VH

// APB byte offsets of the register map.
`define LACC_OFF_WORD        12'h000
`define LACC_OFF_ADAPT_CFG   12'h004
`define LACC_OFF_LOAD_CFG    12'h008
`define LACC_OFF_SAMPLE      12'h00C
`define LACC_OFF_STATUS      12'h010

// Address code in bits 19 to 17 of a configuration word.
`define LACC_ADDR_HI         19
`define LACC_ADDR_LO         17
`define LACC_ADDR_ADAPT      3'h5
`define LACC_ADDR_LOAD       3'h6

// Fields of the load-adaptive configuration word.
`define LACC_MINSEL_BIT      15
`define LACC_DECSPD_HI       14
`define LACC_DECSPD_LO       13
`define LACC_UPOFS_HI        11
`define LACC_UPOFS_LO        8
`define LACC_INCSZ_HI        6
`define LACC_INCSZ_LO        5
`define LACC_LOWTH_HI        3
`define LACC_LOWTH_LO        0

// Fields of the filter, threshold and current scale word.
`define LACC_FILT_BIT        16
`define LACC_LDTHR_HI        14
`define LACC_LDTHR_LO        8
`define LACC_CS_HI           4
`define LACC_CS_LO           0

// Reset values of the two configuration words.
`define LACC_ADAPT_RESET     20'hA0000
`define LACC_LOAD_RESET      20'hC001F

// Threshold unit as a shift: thresholds are multiples of 1 << this (32).
`define LACC_THR_SHIFT       5
// Filter updates once per this many full steps.
`define LACC_FILT_STEPS      3'h4
// Full scale of the adaptive factor.
`define LACC_SCALE_MAX       5'h1F

`endif

// *** core/lacc_cmp.v ***
// Threshold comparator for the load sample against the lower and upper
// thresholds. Assumes a 10-bit unsigned load sample.
`timescale 1ns/1ns
`include "lacc_regs.vh"

module lacc_cmp (
  // Thresholds from configuration.
  input  wire [3:0] lower_threshold,
  input  wire [3:0] upper_threshold_offset,
  // Load sample to test.
  input  wire [9:0] sample,
  // Comparison results.
  output wire       below_low,
  output wire       at_or_above_high
);

  // Eleven bits hold the largest upper threshold of 31 x 32.
  wire [10:0] low_thr;
  wire [10:0] high_thr;

  assign low_thr  = {2'h0, lower_threshold, 5'h00};
  assign high_thr = {1'h0, ({1'h0, lower_threshold} + {1'h0, upper_threshold_offset} + 5'h01),
                    5'h00};

  assign below_low        = ({1'h0, sample} < low_thr);
  assign at_or_above_high = ({1'h0, sample} >= high_thr);

endmodule // lacc_cmp

// *** core/lacc_sat.v ***
// Saturating step of the adaptive scale factor between a floor and a
// ceiling. Pure combinational; no clock.
`timescale 1ns/1ns

module lacc_sat (
  // Present factor and limits.
  input  wire [4:0] cur,
  input  wire [4:0] floor_val,
  input  wire [4:0] ceil_val,
  // Requested change.
  input  wire       inc,
  input  wire       dec,
  input  wire [3:0] inc_amount,
  // Next factor.
  output reg  [4:0] result
);

  reg [5:0] sum;

  always @* begin
    sum = {1'h0, cur} + {2'h0, inc_amount};
    result = cur;
    if (inc) begin
      result = (sum > {1'h0, ceil_val}) ? ceil_val : sum[4:0];
    end else if (dec) begin
      result = (cur > floor_val) ? (cur - 5'h01) : floor_val;
    end
    // Keep within limits even when the limits themselves move.
    if (result < floor_val) begin
      result = floor_val;
    end
    if (result > ceil_val) begin
      result = ceil_val;
    end
  end

endmodule // lacc_sat

// *** core/lacc_top.v ***
// Load-adaptive coil current control: two read-back 20-bit configuration
// words, threshold comparison of load samples and a saturating current
// scaling factor, reached over APB.
// Assumes samples and full-step pulses come synchronous to clk_sys.
//
// Functional notes
// - Address bits 101 and 110 select words.
// - Load word chosen by bits 19-17 = 110.
// - Minimum bit picks half or quarter floor.
// - Zero lower threshold disables adaptation.
// - Sample below lower x 32 increases current.
// - Increment size codes give 1,2,4,8 steps.
// - Enough samples at upper threshold decrement.
// - Decrement speed codes give 32,8,2,1 samples.
// - Filter bit: raw or per-four-fullstep samples.
// - Load threshold is seven-bit signed.
// - Lower threshold means higher sensitivity.
// - Current scale is (code+1)/32.
// - Scale applies to serial and step modes.
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`include "lacc_regs.vh"

module lacc_top (
  // Clock and reset.
  input  wire        clk_sys,
  input  wire        nrst,
  // APB slave.
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Load measurement input.
  input  wire [9:0]  load_measure_value,
  input  wire        load_valid,
  input  wire        fullstep,
  // Coil currents from serial or step/direction path.
  input  wire        step_dir_mode,
  input  wire [8:0]  spi_coil_a,
  input  wire [8:0]  spi_coil_b,
  input  wire [8:0]  sd_coil_a,
  input  wire [8:0]  sd_coil_b,
  // Results.
  output reg  [4:0]  scale_factor,
  output reg  [8:0]  coil_a_scaled,
  output reg  [8:0]  coil_b_scaled,
  output reg  [6:0]  load_threshold_signed,
  output reg         load_filter_enable
);

  // ****************************************************************
  // Configuration storage
  // ****************************************************************

  reg  [19:0] adapt_cfg_reg;          // Load-adaptive configuration word.
  reg  [19:0] load_cfg_reg;           // Filter, threshold, scale word.
  reg  [19:0] bad_word_reg;           // Last word with an unknown address.
  reg  [9:0]  sample_reg;             // Sample used for comparisons.
  reg         sample_vld_reg;         // Pulse: sample_reg freshly updated.
  reg  [9:0]  filt_acc_reg;           // Newest raw sample in filter mode.
  reg  [2:0]  fstep_cnt_reg;          // Full steps since last filtered update.
  reg  [4:0]  dec_cnt_reg;            // Consecutive high samples since last decrement.
  reg         seen_update_reg;        // Sticky: factor changed while adaptation on.

  wire        min_current_select;
  wire [1:0]  decrement_speed;
  wire [3:0]  upper_threshold_offset;
  wire [1:0]  increment_size;
  wire [3:0]  lower_threshold;
  wire [4:0]  current_scale;
  wire        adapt_on;
  wire [4:0]  floor_val;
  wire [3:0]  inc_amount;
  wire [4:0]  dec_need;
  wire        below_low;
  wire        at_high;
  wire        do_inc;
  wire        do_dec;
  wire [4:0]  factor_next;
  wire [2:0]  word_addr;
  wire        apb_wr;

  assign min_current_select     = adapt_cfg_reg[`LACC_MINSEL_BIT];
  assign decrement_speed        = adapt_cfg_reg[`LACC_DECSPD_HI:`LACC_DECSPD_LO];
  assign upper_threshold_offset = adapt_cfg_reg[`LACC_UPOFS_HI:`LACC_UPOFS_LO];
  assign increment_size         = adapt_cfg_reg[`LACC_INCSZ_HI:`LACC_INCSZ_LO];
  assign lower_threshold        = adapt_cfg_reg[`LACC_LOWTH_HI:`LACC_LOWTH_LO];
  assign current_scale          = load_cfg_reg[`LACC_CS_HI:`LACC_CS_LO];

  assign adapt_on = (lower_threshold != 4'h0);

  // half or quarter floor; floor of CS/2 or CS/4 (CS shifted right) in factor units.
  assign floor_val = min_current_select ? ({2'h0, current_scale[4:2]}) :
                                          ({1'h0, current_scale[4:1]});

  assign inc_amount = (increment_size == 2'h0) ? 4'h1 :
                      (increment_size == 2'h1) ? 4'h2 :
                      (increment_size == 2'h2) ? 4'h4 : 4'h8;

  assign dec_need = (decrement_speed == 2'h0) ? 5'h1F :
                    (decrement_speed == 2'h1) ? 5'h07 :
                    (decrement_speed == 2'h2) ? 5'h01 : 5'h00;

  lacc_cmp u_cmp (
    .lower_threshold        (lower_threshold),
    .upper_threshold_offset (upper_threshold_offset),
    .sample                 (sample_reg),
    .below_low              (below_low),
    .at_or_above_high       (at_high)
  );

  assign do_inc = adapt_on && sample_vld_reg && below_low;
  assign do_dec = adapt_on && sample_vld_reg && at_high && (dec_cnt_reg == dec_need);

  lacc_sat u_sat (
    .cur        (scale_factor),
    .floor_val  (floor_val),
    .ceil_val   (current_scale),
    .inc        (do_inc),
    .dec        (do_dec),
    .inc_amount (inc_amount),
    .result     (factor_next)
  );

  // ****************************************************************
  // APB slave, zero wait states
  // ****************************************************************

  // Read data is loaded in every setup cycle, whatever the direction, so
  // reads need no decode of their own. A write never looks at prdata,
  // which keeps the read path free of any pwrite timing.
  assign apb_wr    = psel && penable && pwrite;
  assign word_addr = pwdata[`LACC_ADDR_HI:`LACC_ADDR_LO];

  // The bus answers in the access cycle; pready is registered from setup.
  always @(posedge clk_sys) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        // Unmapped offsets answer with an error and read zero.
        case (paddr)
          `LACC_OFF_WORD: begin
            prdata <= {12'h000, bad_word_reg};
          end
          `LACC_OFF_ADAPT_CFG: begin
            prdata <= {12'h000, adapt_cfg_reg};
          end
          `LACC_OFF_LOAD_CFG: begin
            prdata <= {12'h000, load_cfg_reg};
          end
          `LACC_OFF_SAMPLE: begin
            prdata <= {22'h000000, sample_reg};
          end
          `LACC_OFF_STATUS: begin
            prdata <= {24'h000000, seen_update_reg, adapt_on, 1'b0, scale_factor};
          end
          default: begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // Configuration words arrive through one word port and are routed by
  // their own address bits, the way the serial path delivers them.
  always @(posedge clk_sys) begin
    if (!nrst) begin
      adapt_cfg_reg   <= `LACC_ADAPT_RESET;
      load_cfg_reg    <= `LACC_LOAD_RESET;
      bad_word_reg    <= 20'h00000;
    end else if (apb_wr && (paddr == `LACC_OFF_WORD)) begin
      if (word_addr == `LACC_ADDR_ADAPT) begin
        adapt_cfg_reg <= pwdata[19:0];
      end else if (word_addr == `LACC_ADDR_LOAD) begin
        load_cfg_reg  <= pwdata[19:0];
      end else begin
        bad_word_reg  <= pwdata[19:0];
      end
    end
  end

  // ****************************************************************
  // Load sample path
  // ****************************************************************

  always @(posedge clk_sys) begin
    if (!nrst) begin
      sample_reg     <= 10'h000;
      sample_vld_reg <= 1'b0;
      filt_acc_reg   <= 10'h000;
      fstep_cnt_reg  <= 3'h0;
    end else begin
      sample_vld_reg <= 1'b0;
      if (!load_filter_enable) begin
        fstep_cnt_reg <= 3'h0;
        if (load_valid) begin
          sample_reg     <= load_measure_value;
          sample_vld_reg <= 1'b1;
        end
      end else begin
        if (load_valid) begin
          filt_acc_reg <= load_measure_value;
        end
        // Filtered value released once every four full steps.
        if (fullstep) begin
          if (fstep_cnt_reg == (`LACC_FILT_STEPS - 3'h1)) begin
            fstep_cnt_reg  <= 3'h0;
            sample_reg     <= filt_acc_reg;
            sample_vld_reg <= 1'b1;
          end else begin
            fstep_cnt_reg <= fstep_cnt_reg + 3'h1;
          end
        end
      end
    end
  end

  // ****************************************************************
  // Adaptive factor
  // ****************************************************************

  always @(posedge clk_sys) begin
    if (!nrst) begin
      dec_cnt_reg     <= 5'h00;
      scale_factor    <= `LACC_SCALE_MAX;
      seen_update_reg <= 1'b0;
    end else begin
      if (!adapt_on) begin
        // Disabled: run at the full programmed scale.
        dec_cnt_reg  <= 5'h00;
        scale_factor <= current_scale;
      end else begin
        scale_factor <= factor_next;
        if (factor_next != scale_factor) begin
          seen_update_reg <= 1'b1;
        end
        if (sample_vld_reg) begin
          if (!at_high || do_dec) begin
            dec_cnt_reg <= 5'h00;
          end else begin
            dec_cnt_reg <= dec_cnt_reg + 5'h01;
          end
        end
      end
    end
  end

  // ****************************************************************
  // Outputs: scaled coil currents and load settings
  // ****************************************************************

  // scale by factor+1 over 32; same for both sources.
  always @(posedge clk_sys) begin
    if (!nrst) begin
      coil_a_scaled         <= 9'h000;
      coil_b_scaled         <= 9'h000;
      load_threshold_signed <= 7'h00;
      load_filter_enable    <= 1'b0;
    end else begin
      coil_a_scaled <= scale_mul(step_dir_mode ? sd_coil_a : spi_coil_a, scale_factor);
      coil_b_scaled <= scale_mul(step_dir_mode ? sd_coil_b : spi_coil_b, scale_factor);
      // signed threshold field; lower means more sensitive.
      load_threshold_signed <= load_cfg_reg[`LACC_LDTHR_HI:`LACC_LDTHR_LO];
      load_filter_enable    <= load_cfg_reg[`LACC_FILT_BIT];
    end
  end

  // Multiply by (k+1) and divide by 32; truncation keeps it cheap.
  function [8:0] scale_mul;
    input [8:0] val;
    input [4:0] k;
    reg   [14:0] prod;
    begin
      prod      = {6'h00, val} * {9'h000, ({1'b0, k} + 6'h01)};
      scale_mul = prod[13:5];
    end
  endfunction

endmodule // lacc_top

// *** verif/lacc_checker.sv ***
// Concurrent checks on lacc_top: APB answer timing, coil scaling, factor limits.
// Assumes it sees only the top ports and is attached by the bind below.
`timescale 1ns/1ns
module lacc_checker (
  // Clock and reset.
  input wire logic        clk_sys,
  input wire logic        nrst,
  // APB side.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Coil path and results.
  input wire logic        step_dir_mode,
  input wire logic [8:0]  spi_coil_a,
  input wire logic [8:0]  sd_coil_a,
  input wire logic [4:0]  scale_factor,
  input wire logic [8:0]  coil_a_scaled,
  input wire logic [6:0]  load_threshold_signed
);
  // ****************
  // Snooped settings
  // ****************
  logic [4:0]  cs_q;    // Last current scale written.
  logic [3:0]  low_q;   // Last lower threshold written.
  logic        min_q;   // Last minimum select written.
  logic [6:0]  thr_q;   // Last signed threshold written.
  logic [2:0]  age_q;   // Cycles since a word write, saturating.
  logic [8:0]  exp_a_q; // Expected scaled coil A.
  wire         wr    = psel && penable && pready && pwrite && paddr == 12'h000;
  wire  [2:0]  code  = pwdata[19:17];
  wire  [4:0]  flr   = min_q ? (cs_q >> 2) : (cs_q >> 1);
  wire  [8:0]  src_a = step_dir_mode ? sd_coil_a : spi_coil_a;
  wire  [14:0] prod  = {6'h00, src_a} * ({10'h000, scale_factor} + 15'h0001);
  // Track settings; age lets the factor settle before limits are judged.
  always @(posedge clk_sys) begin
    if (!nrst) begin
      cs_q    <= 5'h1F;
      low_q   <= 4'h0;
      min_q   <= 1'b0;
      thr_q   <= 7'h00;
      age_q   <= 3'h0;
      exp_a_q <= 9'h000;
    end else begin
      if (wr && code == 3'h6) begin
        cs_q  <= pwdata[4:0];
        thr_q <= pwdata[14:8];
      end
      if (wr && code == 3'h5) begin
        low_q <= pwdata[3:0];
        min_q <= pwdata[15];
      end
      age_q   <= wr ? 3'h0 : ((age_q == 3'h7) ? age_q : age_q + 3'h1);
      exp_a_q <= prod[13:5];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence seq_setup; psel && !penable; endsequence
  sequence seq_access; psel && penable; endsequence
  // ****************
  // Assertions
  // ****************
  a_ready_access: assert property (seq_setup ##1 seq_access |-> pready)
    else $error("ready missing in access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_unmapped_err: assert property (psel && penable &&
    (paddr > 12'h010 || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("unmapped access not flagged");
  a_thr_copy: assert property (wr && code == 3'h6 |=> ##[0:1] load_threshold_signed == thr_q)
    else $error("threshold output wrong");
  a_coil_scale: assert property (coil_a_scaled == exp_a_q)
    else $error("coil scaling wrong");
  a_disabled_full: assert property (age_q == 3'h7 && low_q == 4'h0 |-> scale_factor == cs_q)
    else $error("factor not full when disabled");
  a_factor_range: assert property (age_q == 3'h7 |->
    scale_factor <= cs_q && scale_factor >= flr)
    else $error("factor out of range");
endmodule // lacc_checker
bind lacc_top lacc_checker i_chk (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .step_dir_mode(step_dir_mode), .spi_coil_a(spi_coil_a),
  .sd_coil_a(sd_coil_a), .scale_factor(scale_factor), .coil_a_scaled(coil_a_scaled),
  .load_threshold_signed(load_threshold_signed));

// *** verif/tb.sv ***
// Self-checking bench for lacc_top: reset values, word decoding, coil scaling
// table and the adaptive factor. Drives every input port itself; registers over APB.
`timescale 1ns/1ns
module tb;
  logic        clk_sys, nrst, psel, penable, pwrite, load_valid, fullstep;
  logic        step_dir_mode, pready, pslverr, load_filter_enable, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0]  load_measure_value;
  logic [8:0]  spi_coil_a, spi_coil_b, sd_coil_a, sd_coil_b, coil_a_scaled, coil_b_scaled;
  logic [4:0]  scale_factor;
  logic [6:0]  load_threshold_signed;
  int          fail_count, checks, k;
  // One row: mode, coil A, coil B, current scale, expected scaled A and B.
  typedef struct { logic m; logic [8:0] a; logic [8:0] b; logic [4:0] cs;
                   logic [8:0] ea; logic [8:0] eb; } lacc_row_t;
  lacc_row_t   rows [4] = '{'{1'b0, 9'h1FF, 9'h064, 5'h1F, 9'h1FF, 9'h064},
                            '{1'b1, 9'h12C, 9'h007, 5'h00, 9'h009, 9'h000},
                            '{1'b0, 9'h0FF, 9'h100, 5'h0F, 9'h07F, 9'h080},
                            '{1'b1, 9'h1FF, 9'h001, 5'h10, 9'h10F, 9'h000}};
  lacc_top i_dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .load_measure_value(load_measure_value), .load_valid(load_valid),
    .fullstep(fullstep), .step_dir_mode(step_dir_mode), .spi_coil_a(spi_coil_a),
    .spi_coil_b(spi_coil_b), .sd_coil_a(sd_coil_a), .sd_coil_b(sd_coil_b),
    .scale_factor(scale_factor), .coil_a_scaled(coil_a_scaled),
    .coil_b_scaled(coil_b_scaled), .load_threshold_signed(load_threshold_signed),
    .load_filter_enable(load_filter_enable));
  // Free-running 50 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Print counts and verdict, then stop.
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Compare a seen value with its expectation.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits for ready under a bound, then idles one cycle.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin @(posedge clk_sys); n++; end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (pready !== 1'b1) begin fail_count++; final_report(); end
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Send a configuration word and let the factor settle.
  task automatic wcfg(input logic [19:0] w);
    apb(1'b1, 12'h000, {12'h000, w});
    repeat (3) @(posedge clk_sys);
  endtask
  // Present one raw load sample and wait out the compare pipeline.
  task automatic samp(input logic [9:0] v);
    load_measure_value <= v; load_valid <= 1'b1;
    @(posedge clk_sys);
    load_valid <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  initial begin
    nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; load_measure_value = 10'h000; load_valid = 1'b0; fullstep = 1'b0;
    step_dir_mode = 1'b0; spi_coil_a = 9'h000; spi_coil_b = 9'h000;
    sd_coil_a = 9'h000; sd_coil_b = 9'h000; fail_count = 0; checks = 0;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    chk(scale_factor, 32'h1F);
    chk({load_filter_enable, load_threshold_signed}, 32'h0);
    apb(1'b0, 12'h004, 32'h0); chk(rd, 32'hA0000);
    apb(1'b0, 12'h014, 32'h0); chk(er, 32'h1);
    wcfg(20'hE1234); apb(1'b0, 12'h004, 32'h0); chk(rd, 32'hA0000);
    apb(1'b0, 12'h000, 32'h0); chk(rd, 32'hE1234);
    apb(1'b1, 12'h004, 32'hB0000); apb(1'b0, 12'h004, 32'h0); chk(rd, 32'hA0000);
    wcfg(20'hD760F); apb(1'b0, 12'h008, 32'h0); chk(rd, 32'hD760F);
    chk({load_filter_enable, load_threshold_signed}, 32'hF6);
    // Coil scaling table; the unselected source carries the inverse.
    foreach (rows[i]) begin
      wcfg({3'h6, 12'h000, rows[i].cs});
      step_dir_mode <= rows[i].m;
      spi_coil_a <= rows[i].m ? ~rows[i].a : rows[i].a;
      sd_coil_a <= rows[i].m ? rows[i].a : ~rows[i].a;
      spi_coil_b <= rows[i].m ? ~rows[i].b : rows[i].b;
      sd_coil_b <= rows[i].m ? rows[i].b : ~rows[i].b;
      repeat (3) @(posedge clk_sys);
      chk(scale_factor, rows[i].cs);
      chk(coil_a_scaled, rows[i].ea);
      chk(coil_b_scaled, rows[i].eb);
    end
    // Adaptive factor: thresholds 64 and 96, one, eight or 32 samples per decrement.
    wcfg(20'hC000F); wcfg(20'hA6002);
    repeat (10) samp(10'h060);
    chk(scale_factor, 32'h7);
    samp(10'h05F); samp(10'h040); chk(scale_factor, 32'h7);
    wcfg(20'hAE002); repeat (6) samp(10'h060); chk(scale_factor, 32'h3);
    for (k = 0; k < 4; k++) begin
      wcfg(20'(32'hAE002 | (k << 5))); samp(10'h03F);
      chk(scale_factor, 3 + (1 << k));
      if (k < 3) repeat (8) samp(10'h060);
    end
    wcfg(20'hAA002); repeat (7) samp(10'h060); chk(scale_factor, 32'hB);
    samp(10'h060); chk(scale_factor, 32'hA);
    wcfg(20'hA8002); repeat (31) samp(10'h060); chk(scale_factor, 32'hA);
    samp(10'h060); chk(scale_factor, 32'h9);
    wcfg(20'hAE062); samp(10'h000); chk(scale_factor, 32'hF);
    samp(10'h060); chk(scale_factor, 32'hE);
    wcfg(20'hA0000); chk(scale_factor, 32'hF);
    // Filtered samples wait for the fourth full step before they count.
    wcfg(20'hD000F); wcfg(20'hA6002); samp(10'h060);
    for (k = 0; k < 4; k++) begin
      chk(scale_factor, 32'hF);
      fullstep <= 1'b1;
      @(posedge clk_sys);
      fullstep <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
    chk(scale_factor, 32'hE);
    apb(1'b0, 12'h00C, 32'h0); chk(rd, 32'h60);
    apb(1'b0, 12'h010, 32'h0); chk(rd, 32'hCE);
    // Mid-run reset brings back the reset words and full scale.
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    chk(scale_factor, 32'h1F);
    chk({load_filter_enable, load_threshold_signed}, 32'h0);
    apb(1'b0, 12'h008, 32'h0); chk(rd, 32'hC001F);
    apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h0);
    final_report();
  end
endmodule // tb
